/* File: src/lpc_pwm_core.sv */
// How it works
// - one duty value per channel from 01h
// - duty is high byte and low byte
// - reset: 8-bit resolution, 16MHz base
// - divider and resolution set frequency
// - no delay, no inversion: common start
// - phase delay splits six groups of six
// - each group lags by sixth period
// - clear invert bit: whole group phase 1
// - odd outputs turn on at start
// - even outputs turn off at end
// - delay and inversion combine freely
// - detect code 1x written after 00 captures fault flags
// - spread range field drives oscillator
// - one current scale byte per channel
// - global scale applies to all channels
// - shutdown keeps all register contents
// - soft shutdown bit zero stops sinks
// - low shutdown pin disables analog
// - pin rising edge resets host interface
// - registers stay accessible in shutdown
// - detect codes 00/01 store nothing
// - power-on or key write zeroes registers
`timescale 1ns/100ps
`default_nettype none
`include "lpc_params.svh"

module lpc_pwm_core (
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire lpc_pkg::lpc_reg_req_t host_req,
    output logic                 [7:0] host_rdata,
    output logic                       i2c_reset,
    input  wire logic                  hw_shutdown_n_pin,
    input  wire logic           [35:0] short_detect_pin,
    input  wire logic           [35:0] open_detect_pin,
    output logic                [35:0] led_on,
    output lpc_pkg::lpc_analog_t       analog,
    output logic                 [5:0] scale_chan,
    output logic                 [7:0] scale_value
);
    import lpc_pkg::*;

    function automatic logic in_range(input logic [7:0] a,
                                      input logic [7:0] lo,
                                      input logic [7:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction : in_range

    function automatic logic [15:0] res_top(input logic [1:0] res);
        logic [15:0] t;
        t = 16'h00ff;
        case (lpc_res_t'(res))
            LPC_RES_8:  t = 16'h00ff;
            LPC_RES_10: t = 16'h03ff;
            LPC_RES_12: t = 16'h0fff;
            LPC_RES_16: t = 16'hffff;
            default:    t = 16'h00ff;
        endcase
        return t;
    endfunction : res_top

    function automatic logic [15:0] grp_off(input logic [15:0] top,
                                            input logic [2:0]  g);
        logic [19:0] p;
        p = (20'({4'h0, top}) + 20'h1) * 20'({17'h0, g});
        return 16'(p / 20'h6);
    endfunction : grp_off

    // ---------------- pin synchronisers
    logic [2:0]  hw_sync_q;
    logic [35:0] short_m_q;
    logic [35:0] short_s_q;
    logic [35:0] open_m_q;
    logic [35:0] open_s_q;
    logic        i2c_reset_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            hw_sync_q <= 3'h0;
        end else begin
            hw_sync_q <= {hw_sync_q[1:0], hw_shutdown_n_pin};
        end
    end

    always_ff @(posedge core_clk) begin
        short_m_q <= short_detect_pin;
        short_s_q <= short_m_q;
        open_m_q  <= open_detect_pin;
        open_s_q  <= open_m_q;
    end

    wire hw_up   = hw_sync_q[1];
    wire hw_rise = hw_sync_q[1] & ~hw_sync_q[2];

    // only the interface is reset here, never the register contents
    always_ff @(posedge core_clk) begin
        if (rst) begin
            i2c_reset_q <= 1'b0;
        end else begin
            i2c_reset_q <= hw_rise;
        end
    end
    assign i2c_reset = i2c_reset_q;

    // ---------------- register decode
    wire       wr        = host_req.wr;
    wire [7:0] a         = host_req.addr;
    wire [7:0] wd        = host_req.wdata;
    wire       soft_rst  = wr && a == `LPC_ADDR_RESET
                           && wd == `LPC_RESET_KEY;
    wire       clr       = rst | soft_rst;
    wire       duty_hit  = in_range(a, `LPC_ADDR_DUTY_FIRST,
                                    `LPC_ADDR_DUTY_LAST);
    wire       scale_hit = in_range(a, `LPC_ADDR_SCALE_FIRST,
                                    `LPC_ADDR_SCALE_LAST);
    wire       fault_hit = in_range(a, `LPC_ADDR_FAULT_FIRST,
                                    `LPC_ADDR_FAULT_LAST);
    wire [7:0] duty_off  = a - `LPC_ADDR_DUTY_FIRST;
    wire [5:0] duty_ch   = duty_off[6:1];
    wire       duty_hi   = duty_off[0];
    wire [7:0] scale_off = a - `LPC_ADDR_SCALE_FIRST;
    wire [2:0] fault_idx = 3'(a[2:0] - 3'h2);

    logic [7:0]  ctrl_q;
    logic [7:0]  global_q;
    logic [7:0]  phase_q;
    logic [1:0]  fault_mode_q;
    logic [7:0]  spread_q;
    logic [35:0] fault_q;

    // writes are never gated by either shutdown
    always_ff @(posedge core_clk) begin
        if (clr) begin
            ctrl_q       <= `LPC_RESET_BYTE;
            global_q     <= `LPC_RESET_BYTE;
            phase_q      <= `LPC_RESET_BYTE;
            fault_mode_q <= 2'h0;
            spread_q     <= `LPC_RESET_BYTE;
        end else if (wr) begin
            if (a == `LPC_ADDR_CTRL)     ctrl_q       <= wd;
            if (a == `LPC_ADDR_GLOBAL)   global_q     <= wd;
            if (a == `LPC_ADDR_PHASE)    phase_q      <= wd;
            if (a == `LPC_ADDR_FAULT_EN) fault_mode_q <= wd[1:0];
            if (a == `LPC_ADDR_SPREAD)   spread_q     <= wd;
        end
    end

    // a snapshot only; a fault that comes later needs a fresh 00 then 1x
    wire fault_cap = wr && a == `LPC_ADDR_FAULT_EN && wd[1]
                     && fault_mode_q == 2'h0;

    always_ff @(posedge core_clk) begin
        if (clr) begin
            fault_q <= 36'h0;
        end else if (fault_cap) begin
            fault_q <= wd[0] ? open_s_q : short_s_q;
        end
    end

    // ---------------- PWM time base
    logic [5:0]  acc_q;
    logic [6:0]  pre_q;
    logic [15:0] cnt_q;

    wire [6:0]  acc_sum   = {1'b0, acc_q} + 7'(`LPC_ACC_INC);
    wire        ring_tick = acc_sum >= 7'(`LPC_ACC_MOD);
    wire [5:0]  acc_d     = ring_tick ? 6'(acc_sum - 7'(`LPC_ACC_MOD))
                                      : acc_sum[5:0];
    wire [2:0]  div_sel   = ctrl_q[`LPC_CTRL_DIV_LSB +: 3];
    wire [6:0]  pre_mask  = 7'((8'h01 << div_sel) - 8'h01);
    wire        pwm_step  = ring_tick
                            && (pre_q & pre_mask) == pre_mask;
    wire [15:0] top       = res_top(ctrl_q[`LPC_CTRL_RES_LSB +: 2]);
    wire        delay_en  = phase_q[`LPC_PHASE_DELAY_BIT];
    wire        drive_en  = ctrl_q[`LPC_CTRL_SOFT_ON_BIT] & hw_up;

    always_ff @(posedge core_clk) begin
        if (clr) begin
            acc_q <= 6'h0;
            pre_q <= 7'h0;
            cnt_q <= 16'h0;
        end else begin
            acc_q <= acc_d;
            if (ring_tick) pre_q <= pre_q + 7'h1;
            if (pwm_step) begin
                cnt_q <= (cnt_q >= top) ? 16'h0 : cnt_q + 16'h1;
            end
        end
    end

    // ---------------- group phase offsets
    logic [15:0] grp_cnt  [`LPC_GROUPS];
    logic [15:0] grp_offs [`LPC_GROUPS];
    logic [5:0]  grp_wrap;

    genvar g;
    generate
        for (g = 0; g < `LPC_GROUPS; g++) begin : g_grp
            // offsets collapse to zero with delay off: common start
            assign grp_offs[g] = delay_en ? grp_off(top, 3'(g))
                                          : 16'h0;
            assign grp_cnt[g]  = (cnt_q >= grp_offs[g])
                ? cnt_q - grp_offs[g]
                : 16'({1'b0, cnt_q} + {1'b0, top} + 17'h1
                      - {1'b0, grp_offs[g]});
            assign grp_wrap[g] = pwm_step && grp_cnt[g] == top;
        end
    endgenerate

    // ---------------- per-channel duty and outputs
    logic [15:0] duty_pend_q [`LPC_CHANNELS];
    logic [15:0] duty_act_q  [`LPC_CHANNELS];

    genvar c;
    generate
        for (c = 0; c < `LPC_CHANNELS; c++) begin : g_ch
            localparam int GI = c / `LPC_GROUP_SIZE;
            localparam int PI = c % `LPC_GROUP_SIZE;
            wire        hit_lo = wr && duty_hit && duty_ch == 6'(c)
                                 && !duty_hi;
            wire        hit_hi = wr && duty_hit && duty_ch == 6'(c)
                                 && duty_hi;
            wire [15:0] eff    = duty_act_q[c] & top;
            wire [15:0] cg     = grp_cnt[GI];
            wire        on_p1  = cg < eff;
            wire        on_p2  = ({1'b0, cg} + {1'b0, eff})
                                 > {1'b0, top};
            // only 2nd, 4th, 6th of a group may move to phase 2
            wire        inv    = phase_q[GI] && PI % 2 == 1;
            wire        dc     = spread_q[`LPC_SPREAD_DC_LSB
                                          + c / `LPC_DC_BANK];
            wire        on     = dc | (inv ? on_p2 : on_p1);

            always_ff @(posedge core_clk) begin
                if (clr) begin
                    duty_pend_q[c] <= 16'h0;
                end else if (hit_lo) begin
                    duty_pend_q[c][7:0] <= wd;
                end else if (hit_hi) begin
                    duty_pend_q[c][15:8] <= wd;
                end
            end

            // swap only at this group's wrap: no cut pulses
            always_ff @(posedge core_clk) begin
                if (clr) begin
                    duty_act_q[c] <= 16'h0;
                    led_on[c]     <= 1'b0;
                end else begin
                    if (grp_wrap[GI]) begin
                        duty_act_q[c] <= duty_pend_q[c];
                    end
                    led_on[c] <= on & drive_en;
                end
            end
        end
    endgenerate

    // ---------------- current scale memory
    logic [5:0] scan_q;
    logic [5:0] scan_chan_q;
    logic [7:0] mem_rdata;
    logic [5:0] mem_raddr_q;
    // last read address is held so scale data stand until the next read
    wire  [5:0] mem_raddr = host_req.rd ? scale_off[5:0] : mem_raddr_q;

    lpc_regmem u_scale (
        .core_clk  (core_clk),
        .clr       (clr),
        .we        (wr && scale_hit),
        .waddr     (scale_off[5:0]),
        .wdata     (wd),
        .raddr     (mem_raddr),
        .rdata     (mem_rdata),
        .scan_addr (scan_q),
        .scan_data (scale_value)
    );

    // the analog side is refreshed round-robin, one channel a cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            scan_q      <= 6'h0;
            scan_chan_q <= 6'h0;
        end else begin
            scan_q      <= (scan_q == 6'(`LPC_CHANNELS - 1)) ? 6'h0
                                                             : scan_q + 6'h1;
            scan_chan_q <= scan_q;
        end
    end
    assign scale_chan = scan_chan_q;

    // ---------------- analog controls
    assign analog.analog_enable        = hw_up;
    assign analog.sink_enable          = drive_en;
    assign analog.global_current_scale = global_q;
    assign analog.spread_enable        = spread_q[`LPC_SPREAD_EN_BIT];
    assign analog.spread_range         =
        spread_q[`LPC_SPREAD_RANGE_LSB +: 2];
    assign analog.spread_cycle         = spread_q[1:0];

    // ---------------- read path, one cycle latency
    wire [39:0] fault_wide = {4'h0, fault_q};
    wire [15:0] pend_sel   = duty_pend_q[duty_ch];
    logic [7:0] rd_local;
    logic [7:0] rd_q;
    logic       sel_mem_q;

    always_comb begin
        rd_local = 8'h00;
        if (a == `LPC_ADDR_CTRL)          rd_local = ctrl_q;
        else if (duty_hit)                rd_local = duty_hi ? pend_sel[15:8]
                                                             : pend_sel[7:0];
        else if (a == `LPC_ADDR_GLOBAL)   rd_local = global_q;
        else if (a == `LPC_ADDR_PHASE)    rd_local = phase_q;
        else if (a == `LPC_ADDR_FAULT_EN) rd_local = {6'h0, fault_mode_q};
        else if (fault_hit)               rd_local = fault_wide[fault_idx*8 +: 8];
        else if (a == `LPC_ADDR_SPREAD)   rd_local = spread_q;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_q        <= 8'h00;
            sel_mem_q   <= 1'b0;
            mem_raddr_q <= 6'h0;
        end else if (host_req.rd) begin
            rd_q        <= rd_local;
            sel_mem_q   <= scale_hit;
            mem_raddr_q <= scale_off[5:0];
        end
    end
    assign host_rdata = sel_mem_q ? mem_rdata : rd_q;

    // ---------------- checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_SOFT_OFF: assert property (
        !ctrl_q[`LPC_CTRL_SOFT_ON_BIT] && !soft_rst |=> led_on == 36'h0)
        else $error("outputs on during soft shutdown");

    AST_HW_OFF: assert property (
        !hw_up |-> !analog.analog_enable ##1 led_on == 36'h0)
        else $error("outputs on during hardware shutdown");

    AST_PIN_EDGE: assert property (
        $rose(hw_up) |=> i2c_reset ##1 !i2c_reset)
        else $error("interface reset pulse wrong");

    AST_KEY_CLEAR: assert property (
        soft_rst |=> ctrl_q == 8'h00 && phase_q == 8'h00
                     && fault_q == 36'h0 && duty_pend_q[0] == 16'h0)
        else $error("reset key did not clear registers");

    AST_NO_CAPTURE: assert property (
        wr && a == `LPC_ADDR_FAULT_EN && !wd[1] && !soft_rst
        |=> $stable(fault_q))
        else $error("fault flags changed with detect off");

    AST_CAPTURE: assert property (
        fault_cap && !soft_rst |=> fault_q ==
            ($past(wd[0]) ? $past(open_s_q) : $past(short_s_q)))
        else $error("fault flags not captured");

    AST_COMMON_START: assert property (
        !delay_en |-> grp_cnt[0] == grp_cnt[5] && grp_wrap[0] == grp_wrap[5])
        else $error("groups not aligned with delay off");

    AST_DUTY_HOLD: assert property (
        !grp_wrap[0] && !clr |=> $stable(duty_act_q[0]))
        else $error("duty changed mid cycle");

    AST_SHUTDOWN_WRITE: assert property (
        !hw_up && wr && a == `LPC_ADDR_GLOBAL && !soft_rst
        |=> global_q == $past(wd))
        else $error("register write lost in shutdown");

endmodule : lpc_pwm_core

`default_nettype wire

/* File: common/lpc_params.svh */
`ifndef LPC_PARAMS_SVH
`define LPC_PARAMS_SVH

// register offsets
`define LPC_ADDR_CTRL        8'h00
`define LPC_ADDR_DUTY_FIRST  8'h01
`define LPC_ADDR_DUTY_LAST   8'h48
`define LPC_ADDR_SCALE_FIRST 8'h4a
`define LPC_ADDR_SCALE_LAST  8'h6d
`define LPC_ADDR_GLOBAL      8'h6e
`define LPC_ADDR_PHASE       8'h70
`define LPC_ADDR_FAULT_EN    8'h71
`define LPC_ADDR_FAULT_FIRST 8'h72
`define LPC_ADDR_FAULT_LAST  8'h76
`define LPC_ADDR_SPREAD      8'h78
`define LPC_ADDR_RESET       8'h7f

// field positions
`define LPC_CTRL_SOFT_ON_BIT 0
`define LPC_CTRL_RES_LSB     1
`define LPC_CTRL_DIV_LSB     4
`define LPC_PHASE_DELAY_BIT  7
`define LPC_SPREAD_EN_BIT    4
`define LPC_SPREAD_RANGE_LSB 2
`define LPC_SPREAD_DC_LSB    5

// reset values
`define LPC_RESET_BYTE       8'h00
`define LPC_RESET_KEY        8'h00

// geometry
`define LPC_CHANNELS         36
`define LPC_GROUPS           6
`define LPC_GROUP_SIZE       6
`define LPC_DC_BANK          12

// timing: ring oscillator rate emulated from the core clock
`define LPC_RING_HZ          16000000
`define LPC_CLK_HZ           50000000
`define LPC_ACC_INC          (`LPC_RING_HZ / 1000000)
`define LPC_ACC_MOD          (`LPC_CLK_HZ / 1000000)

`endif

/* File: common/lpc_pkg.sv */
package lpc_pkg;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lpc_reg_req_t;

    typedef struct packed {
        logic       analog_enable;
        logic       sink_enable;
        logic [7:0] global_current_scale;
        logic       spread_enable;
        logic [1:0] spread_range;
        logic [1:0] spread_cycle;
    } lpc_analog_t;

    typedef enum logic [1:0] {
        LPC_RES_8  = 2'h0,
        LPC_RES_10 = 2'h1,
        LPC_RES_12 = 2'h2,
        LPC_RES_16 = 2'h3
    } lpc_res_t;

endpackage : lpc_pkg

/* File: src/lpc_regmem.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lpc_params.svh"

module lpc_regmem (
    input  wire logic       core_clk,
    input  wire logic       clr,
    input  wire logic       we,
    input  wire logic [5:0] waddr,
    input  wire logic [7:0] wdata,
    input  wire logic [5:0] raddr,
    output logic      [7:0] rdata,
    input  wire logic [5:0] scan_addr,
    output logic      [7:0] scan_data
);
    import lpc_pkg::*;

    logic [7:0] mem_q [`LPC_CHANNELS];

    // clear is swept in one cycle so a soft reset needs no walk
    genvar i;
    generate
        for (i = 0; i < `LPC_CHANNELS; i++) begin : g_word
            always_ff @(posedge core_clk) begin
                if (clr) begin
                    mem_q[i] <= `LPC_RESET_BYTE;
                end else if (we && waddr == 6'(i)) begin
                    mem_q[i] <= wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        rdata     <= mem_q[raddr];
        scan_data <= mem_q[scan_addr];
    end

endmodule : lpc_regmem

`default_nettype wire

/* File: verif/lpc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

module lpc_host_model (
    input  wire logic                  core_clk,
    output lpc_pkg::lpc_reg_req_t      host_req,
    input  wire logic            [7:0] host_rdata
);
    import lpc_pkg::*;

    initial host_req = '0;

    // one strobe per byte, raised after a falling edge and held over one
    // rising edge; the idle cycle after keeps strobes from merging
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        host_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge core_clk);
        host_req = '0;
    endtask : write_reg

    // read data is registered on the taking edge, so it is settled here
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        host_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge core_clk);
        host_req = '0;
        d = host_rdata;
    endtask : read_reg
endmodule : lpc_host_model

`default_nettype wire

/* File: verif/test_led_pwm_channel_control.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lpc_params.svh"

module test_led_pwm_channel_control;
    import lpc_pkg::*;

    logic         core_clk;
    logic         rst;
    logic         pin_n;
    logic  [35:0] short_pins;
    logic  [35:0] open_pins;
    logic  [35:0] led_on;
    lpc_reg_req_t host_req;
    logic   [7:0] host_rdata;
    logic         i2c_reset;
    lpc_analog_t  analog;
    logic   [5:0] scale_chan;
    logic   [7:0] scale_value;
    logic   [7:0] rd;
    logic   [7:0] probe [6] = '{8'h00, 8'h01, 8'h4a, 8'h70, 8'h72, 8'h78};
    int           failures = 0;
    int           compares = 0;
    int           ra, rb, fb, ha, hb, na, hs, ns;

    lpc_pwm_core dut (
        .core_clk         (core_clk),
        .rst              (rst),
        .host_req         (host_req),
        .host_rdata       (host_rdata),
        .i2c_reset        (i2c_reset),
        .hw_shutdown_n_pin(pin_n),
        .short_detect_pin (short_pins),
        .open_detect_pin  (open_pins),
        .led_on           (led_on),
        .analog           (analog),
        .scale_chan       (scale_chan),
        .scale_value      (scale_value)
    );

    lpc_host_model host (
        .core_clk  (core_clk),
        .host_req  (host_req),
        .host_rdata(host_rdata)
    );

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [35:0] seen,
                         input logic [35:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        if (failures == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    task automatic rdchk(input string what, input logic [7:0] a,
                         input logic [7:0] exp);
        host.read_reg(a, rd);
        check(what, rd, exp);
    endtask : rdchk

    // one 1600-cycle window: first rise of a and b, first fall of b,
    // cycles high of both, rises of a
    task automatic watch(input int a, input int b);
        logic pa, pb;
        ra = -1; rb = -1; fb = -1; ha = 0; hb = 0; na = 0;
        pa = led_on[a];
        pb = led_on[b];
        for (int i = 0; i < 1600; i++) begin
            @(negedge core_clk);
            if (led_on[a] && !pa) begin
                na++;
                if (ra < 0) ra = i;
            end
            if (led_on[b] && !pb && rb < 0) rb = i;
            if (!led_on[b] && pb && fb < 0) fb = i;
            ha += int'(led_on[a]);
            hb += int'(led_on[b]);
            pa = led_on[a];
            pb = led_on[b];
        end
    endtask : watch

    // four steps of 16MHz ticks, twice per window: 24 to 26 core cycles
    function automatic logic width_ok(input int h);
        return (h >= 24 && h <= 26);
    endfunction : width_ok

    initial begin
        repeat (60000) @(posedge core_clk);
        failures++;
        tally_and_finish;
    end

    initial begin
        rst = 1'b1;
        pin_n = 1'b1;
        short_pins = '0;
        open_pins = '0;
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        repeat (4) @(negedge core_clk);
        foreach (probe[i]) rdchk("reset value", probe[i], 8'h00);
        check("sink after reset", analog.sink_enable, 1'b0);
        for (int r = 0; r < 4; r++) begin
            host.write_reg(`LPC_ADDR_SPREAD, {3'h0, 1'b1, r[1:0], 2'h1});
            repeat (2) @(negedge core_clk);
            check("spread range", analog.spread_range, r[1:0]);
            check("spread on", analog.spread_enable, 1'b1);
            check("spread cycle", analog.spread_cycle, 2'h1);
        end
        host.write_reg(`LPC_ADDR_GLOBAL, 8'h40);
        repeat (2) @(negedge core_clk);
        check("global scale", analog.global_current_scale, 8'h40);
        host.write_reg(8'h4a, 8'h80);
        host.write_reg(8'h4b, 8'h33);
        rdchk("scale 0", 8'h4a, 8'h80);
        for (int i = 0; i < 40; i++) begin
            @(negedge core_clk);
            if (scale_chan === 6'h01)
                check("scale port", scale_value, 8'h33);
        end
        // channels 0, 3 (group 0) and 7 (group 1) get four steps
        host.write_reg(8'h01, 8'h04);
        host.write_reg(8'h02, 8'h00);
        host.write_reg(8'h07, 8'h04);
        host.write_reg(8'h0f, 8'h04);
        host.write_reg(`LPC_ADDR_CTRL, 8'h01);
        rdchk("duty low", 8'h01, 8'h04);
        repeat (1700) @(negedge core_clk);
        watch(0, 7);
        check("pulse width", width_ok(ha), 1'b1);
        check("8-bit period", na, 2);
        check("common start", rb, ra);
        host.write_reg(`LPC_ADDR_CTRL, 8'h11);
        repeat (1700) @(negedge core_clk);
        watch(0, 7);
        check("divided width", width_ok(ha), 1'b1);
        check("divided period", na, 1);
        // 1024-step period spans two windows: one pulse of four ticks
        host.write_reg(`LPC_ADDR_CTRL, 8'h03);
        repeat (2) @(negedge core_clk);
        watch(0, 7);
        hs = ha;
        ns = na;
        watch(0, 7);
        hs += ha;
        check("10-bit period", ns + na, 1);
        check("10-bit width", (hs >= 12 && hs <= 13), 1'b1);
        host.write_reg(`LPC_ADDR_CTRL, 8'h01);
        host.write_reg(`LPC_ADDR_PHASE, 8'h80);
        repeat (1700) @(negedge core_clk);
        watch(0, 7);
        // group 1 lags 42 steps of 3.125 cycles
        rb = (rb - ra + 800) % 800;
        check("group lag", (rb >= 130 && rb <= 133), 1'b1);
        watch(0, 3);
        check("same group", rb, ra);
        host.write_reg(8'h03, 8'h04);
        host.write_reg(`LPC_ADDR_PHASE, 8'h81);
        repeat (1700) @(negedge core_clk);
        watch(0, 1);
        check("phase 2 end", fb, ra);
        check("phase 2 width", width_ok(hb), 1'b1);
        // first bank forced on, last bank still follows its zero duty
        host.write_reg(`LPC_ADDR_SPREAD, 8'h20);
        repeat (2) @(negedge core_clk);
        check("bank forced on", led_on[11:0], 12'hfff);
        check("bank left on pwm", led_on[35:24], 12'h000);
        host.write_reg(`LPC_ADDR_SPREAD, 8'h00);
        short_pins = 36'h8_0000_0005;
        repeat (3) @(negedge core_clk);
        host.write_reg(`LPC_ADDR_FAULT_EN, 8'h02);
        rdchk("short low", 8'h72, 8'h05);
        rdchk("short high", 8'h76, 8'h08);
        short_pins = '0;
        open_pins = 36'h0_0000_0300;
        repeat (3) @(negedge core_clk);
        host.write_reg(`LPC_ADDR_FAULT_EN, 8'h01);
        rdchk("no capture", 8'h72, 8'h05);
        host.write_reg(`LPC_ADDR_FAULT_EN, 8'h00);
        host.write_reg(`LPC_ADDR_FAULT_EN, 8'h03);
        rdchk("open flags", 8'h73, 8'h03);
        pin_n = 1'b0;
        repeat (5) @(negedge core_clk);
        check("outputs in shutdown", led_on, 36'h0);
        check("analog in shutdown", analog.analog_enable, 1'b0);
        host.write_reg(8'h4a, 8'h55);
        rdchk("write in shutdown", 8'h4a, 8'h55);
        rdchk("duty kept", 8'h01, 8'h04);
        host.write_reg(`LPC_ADDR_GLOBAL, 8'h40);
        pin_n = 1'b1;
        na = 0;
        repeat (8) begin
            @(negedge core_clk);
            na += int'(i2c_reset);
        end
        check("interface reset", na, 1);
        check("analog back", analog.analog_enable, 1'b1);
        check("global after wake", analog.global_current_scale, 8'h40);
        rdchk("duty after wake", 8'h0f, 8'h04);
        host.write_reg(`LPC_ADDR_CTRL, 8'h00);
        repeat (2) @(negedge core_clk);
        check("soft off", analog.sink_enable, 1'b0);
        rdchk("read in soft off", 8'h07, 8'h04);
        host.write_reg(`LPC_ADDR_RESET, 8'h00);
        rdchk("key clears duty", 8'h01, 8'h00);
        rdchk("key clears scale", 8'h4a, 8'h00);
        rdchk("unmapped", 8'h49, 8'h00);
        tally_and_finish;
    end
endmodule : test_led_pwm_channel_control

`default_nettype wire
